// ---- rtl/iosk_decoder.sv ----
// Skip-instruction decoder: selects an information register, compares it
// with the comparison quantity and returns the skip verdict.
// Assumes instruction and register inputs come from logic on i_clk.
`timescale 1ns/1ps
module iosk_decoder
  import iosk_pkg::*;
(
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rstn,
  // Instruction from fetch
  input  wire logic                   i_instr_valid,
  input  wire logic [0:WORD_W-1]      i_instr,
  // Tape processor information registers
  input  wire logic [CNT_HI:CNT_LO]   i_asm_counter,
  input  wire logic [0:UNITS-1][UAV_HI:UAV_LO] i_unit_avail,
  input  wire logic [AAV_HI:AAV_LO]   i_asm_avail,
  input  wire logic [AFL_HI:AFL_LO]   i_asm_fault,
  // Buffer controller, drum, paper tape, real-time registers
  input  wire logic [BFL_HI:BFL_LO]   i_buf_fault,
  input  wire logic [DFL_HI:DFL_LO]   i_drum_fault,
  input  wire logic [PTS_HI:PTS_LO]   i_pt_status,
  input  wire logic                   i_pt_fault,
  input  wire logic [RT_HI:RT_LO]     i_rt_in_status,
  input  wire logic [RT_HI:RT_LO]     i_rt_out_status,
  // Verdict to the processor
  output logic                        o_done,
  output logic                        o_skip,
  output iosk_kind_t                  o_kind,
  output logic [UNIT_HI:UNIT_LO]      o_unit
);

  logic        rst_s1_r;   // Reset release, first stage
  logic        rst_n_r;    // Synchronised reset used by the design
  logic [0:WORD_W-1] image_c;  // Addressed register placed at its positions
  iosk_kind_t  kind_c;     // Decoded register
  logic        func_c;     // Function bit
  logic        sel_c;      // Selector bit
  logic [1:0]  sc_c;       // Sub-command code
  logic        done_nxt;
  logic        skip_nxt;
  iosk_kind_t  kind_nxt;
  logic [UNIT_HI:UNIT_LO] unit_nxt;
  logic        done_r;
  logic        skip_r;
  iosk_kind_t  kind_r;
  logic [UNIT_HI:UNIT_LO] unit_r;

  iosk_cmp_if cmp_bus ();  // Operands to the comparator

  // Reset release through two flops
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_s1_r <= SYNC_RST;
      rst_n_r  <= SYNC_RST;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // Decode and register selection
  always_comb begin
    sel_c   = i_instr[SEL_POS];
    func_c  = i_instr[FUNC_POS];
    sc_c    = i_instr[SC_HI:SC_LO];
    kind_c  = IOSK_NONE;
    image_c = '0;
    if (!func_c) begin
      if (sel_c) begin
        kind_c = IOSK_COUNTER;
        image_c[CNT_HI:CNT_LO] = i_asm_counter;
      end else begin
        unique case (sc_c)
          SC_BUF_TAPE: begin
            kind_c = IOSK_UNIT_AVAIL;
            image_c[UAV_HI:UAV_LO] = i_unit_avail[i_instr[UNIT_HI:UNIT_LO]];
          end
          SC_ASM_DRUM: begin
            kind_c = IOSK_ASM_AVAIL;
            image_c[AAV_HI:AAV_LO] = i_asm_avail;
          end
          SC_REALTIME: begin
            // Direction bit picks input or output readiness
            if (i_instr[RTDIR_POS]) begin
              kind_c = IOSK_RT_IN;
              image_c[RT_HI:RT_LO] = i_rt_in_status;
            end else begin
              kind_c = IOSK_RT_OUT;
              image_c[RT_HI:RT_LO] = i_rt_out_status;
            end
          end
          SC_PAPER: begin
            kind_c = IOSK_PT_STAT;
            image_c[PTS_HI:PTS_LO] = i_pt_status;
          end
        endcase
      end
    end else begin
      if (sel_c) begin
        kind_c = IOSK_ASM_FAULT;
        image_c[AFL_HI:AFL_LO] = i_asm_fault;
      end else begin
        unique case (sc_c)
          SC_BUF_TAPE: begin
            kind_c = IOSK_BUF_FAULT;
            image_c[BFL_HI:BFL_LO] = i_buf_fault;
            image_c[BFL_MECH] = 1'b0;
          end
          SC_ASM_DRUM: begin
            kind_c = IOSK_DRUM_FAULT;
            image_c[DFL_HI:DFL_LO] = i_drum_fault;
          end
          SC_PAPER: begin
            kind_c = IOSK_PT_FAULT;
            image_c[PTF_POS] = i_pt_fault;
          end
          SC_REALTIME: begin
            // No fault register here: reads as all zeros
            kind_c = IOSK_NONE;
          end
        endcase
      end
    end
  end

  // Comparator operands
  always_comb begin
    // Register bits passed with their own polarity
    // All ten information registers reachable, four of them tape processor registers
    cmp_bus.reg_word = image_c[CQ_HI:CQ_LO];
    cmp_bus.cq       = i_instr[CQ_HI:CQ_LO];
    // Selector 0 removes sub-command from CQ
    if (!sel_c) begin
      cmp_bus.cq[0:SC_LO-CQ_HI] = '0;
    end
  end

  iosk_cmp u_cmp (
    .cmp_io (cmp_bus.cmp)
  );

  // Verdict next values
  always_comb begin
    done_nxt = i_instr_valid;
    skip_nxt = skip_r;
    kind_nxt = kind_r;
    unit_nxt = unit_r;
    if (i_instr_valid) begin
      skip_nxt = cmp_bus.skip;
      kind_nxt = kind_c;
      unit_nxt = i_instr[UNIT_HI:UNIT_LO];
    end
  end

  // Verdict registers
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      done_r <= DONE_RST;
      skip_r <= SKIP_RST;
      kind_r <= IOSK_NONE;
      unit_r <= '0;
    end else begin
      done_r <= done_nxt;
      skip_r <= skip_nxt;
      kind_r <= kind_nxt;
      unit_r <= unit_nxt;
    end
  end

  assign o_done = done_r;
  assign o_skip = skip_r;
  assign o_kind = kind_r;
  assign o_unit = unit_r;

  // Checks
  default clocking dc @(posedge i_clk); endclocking
  default disable iff (!rst_n_r);

  sequence status_req_s;
    i_instr_valid && !i_instr[FUNC_POS];
  endsequence
  sequence fault_req_s;
    i_instr_valid && i_instr[FUNC_POS];
  endsequence
  // Status skip aimed at a real-time channel
  sequence rt_status_s;
    status_req_s ##0 (!i_instr[SEL_POS] && i_instr[SC_HI:SC_LO] == SC_REALTIME);
  endsequence

  verdict_timing_a: assert property (
    i_instr_valid |=> o_done ##1 (o_done == $past(i_instr_valid)))
    else $error("verdict not one cycle after request");
  done_pulse_a: assert property (
    !i_instr_valid |=> !o_done)
    else $error("verdict without request");
  skip_value_a: assert property (
    i_instr_valid |=> o_skip == ($past(cmp_bus.reg_word) <= $past(cmp_bus.cq)))
    else $error("skip verdict does not match compare");
  zero_skip_a: assert property (
    i_instr_valid && cmp_bus.reg_word == '0 |=> o_skip)
    else $error("zero register did not skip");
  counter_skip_a: assert property (
    status_req_s ##0 i_instr[SEL_POS]
    |=> o_skip == ($past(i_asm_counter) <= $past(i_instr[CQ_HI:CQ_LO])))
    else $error("counter skip verdict wrong");
  counter_select_a: assert property (
    status_req_s ##0 i_instr[SEL_POS] |=> o_kind == IOSK_COUNTER)
    else $error("selector 1 status skip not counter");
  status_kind_a: assert property (
    status_req_s |=> o_kind inside {IOSK_COUNTER, IOSK_UNIT_AVAIL, IOSK_ASM_AVAIL,
                                    IOSK_RT_IN, IOSK_RT_OUT, IOSK_PT_STAT})
    else $error("status skip read a fault register");
  fault_select_a: assert property (
    fault_req_s ##0 i_instr[SEL_POS] |=> o_kind == IOSK_ASM_FAULT)
    else $error("selector 1 fault skip not assembler fault");
  unit_select_a: assert property (
    status_req_s ##0 (!i_instr[SEL_POS] && i_instr[SC_HI:SC_LO] == SC_BUF_TAPE)
    |-> cmp_bus.reg_word[UAV_HI-CQ_HI:UAV_LO-CQ_HI]
        == i_unit_avail[i_instr[UNIT_HI:UNIT_LO]])
    else $error("wrong unit availability bits");
  unit_report_a: assert property (
    i_instr_valid |=> o_unit == $past(i_instr[UNIT_HI:UNIT_LO]))
    else $error("unit field not reported");
  asm_avail_a: assert property (
    status_req_s ##0 (!i_instr[SEL_POS] && i_instr[SC_HI:SC_LO] == SC_ASM_DRUM)
    |=> o_kind == IOSK_ASM_AVAIL)
    else $error("assembler availability not selected");
  rt_in_a: assert property (
    rt_status_s ##0 i_instr[RTDIR_POS] |=> o_kind == IOSK_RT_IN)
    else $error("real-time input not selected");
  rt_out_a: assert property (
    rt_status_s ##0 !i_instr[RTDIR_POS] |=> o_kind == IOSK_RT_OUT)
    else $error("real-time output not selected");
  paper_select_a: assert property (
    status_req_s ##0 (!i_instr[SEL_POS] && i_instr[SC_HI:SC_LO] == SC_PAPER)
    |=> o_kind == IOSK_PT_STAT)
    else $error("paper tape status not selected");
  buf_fault_a: assert property (
    fault_req_s ##0 (!i_instr[SEL_POS] && i_instr[SC_HI:SC_LO] == SC_BUF_TAPE)
    |=> o_kind == IOSK_BUF_FAULT)
    else $error("buffer fault not selected");
  mech_unused_a: assert property (
    kind_c == IOSK_BUF_FAULT |-> !cmp_bus.reg_word[BFL_MECH-CQ_HI])
    else $error("mechanical fault position reported");
  asm_fault_a: assert property (
    fault_req_s ##0 i_instr[SEL_POS]
    |-> cmp_bus.reg_word[AFL_HI-CQ_HI:AFL_LO-CQ_HI] == i_asm_fault)
    else $error("assembler fault positions misaligned");
  fault_skip_a: assert property (
    fault_req_s ##0 i_instr[SEL_POS]
    |=> o_skip == ({1'b0, $past(i_asm_fault)} <= $past(i_instr[CQ_HI:CQ_LO])))
    else $error("assembler fault skip verdict wrong");
  cq_fold_a: assert property (
    !i_instr[SEL_POS] |-> cmp_bus.cq[0:SC_LO-CQ_HI] == 2'h0)
    else $error("sub-command leaked into CQ");
  avail_unused_a: assert property (
    kind_c == IOSK_ASM_AVAIL |-> cmp_bus.reg_word[0:AAV_HI-CQ_HI-1] == '0)
    else $error("unimplemented positions not zero");
  none_skip_a: assert property (
    fault_req_s ##0 (!i_instr[SEL_POS] && i_instr[SC_HI:SC_LO] == SC_REALTIME)
    |=> o_skip)
    else $error("missing fault register did not skip");

endmodule

// ---- rtl/iosk_pkg.sv ----
// Constants and types shared by the skip decoder and its comparator.
// Bit positions follow the instruction word numbering: position 0 is the
// most significant bit, position 23 the least significant.
package iosk_pkg;

  // Instruction word layout
  localparam int WORD_W    = 24;
  localparam int SEL_POS   = 0;
  localparam int UNIT_HI   = 1;
  localparam int UNIT_LO   = 4;
  localparam int RTDIR_POS = 4;
  localparam int SC_HI     = 5;
  localparam int SC_LO     = 6;
  localparam int CQ_HI     = 5;
  localparam int CQ_LO     = 15;
  localparam int CQ_W      = CQ_LO - CQ_HI + 1;
  localparam int FUNC_POS  = 16;

  // Sub-command codes when the selector is 0
  localparam logic [1:0] SC_BUF_TAPE = 2'h0;
  localparam logic [1:0] SC_ASM_DRUM = 2'h1;
  localparam logic [1:0] SC_REALTIME = 2'h2;
  localparam logic [1:0] SC_PAPER    = 2'h3;

  // Field positions of each information register within the word image
  localparam int CNT_HI   = 5;
  localparam int CNT_LO   = 15;
  localparam int UAV_HI   = 10;
  localparam int UAV_LO   = 13;
  localparam int AAV_HI   = 8;
  localparam int AAV_LO   = 15;
  localparam int PTS_HI   = 14;
  localparam int PTS_LO   = 15;
  localparam int RT_HI    = 11;
  localparam int RT_LO    = 13;
  localparam int AFL_HI   = 6;
  localparam int AFL_LO   = 15;
  localparam int BFL_HI   = 11;
  localparam int BFL_LO   = 15;
  localparam int BFL_MECH = 11;
  localparam int DFL_HI   = 14;
  localparam int DFL_LO   = 15;
  localparam int PTF_POS  = 15;
  localparam int UNITS    = 16;

  // Values after reset
  localparam logic DONE_RST = 1'b0;
  localparam logic SKIP_RST = 1'b0;
  localparam logic SYNC_RST = 1'b0;

  // Register addressed by a decoded skip
  typedef enum logic [3:0] {
    IOSK_NONE       = 4'h0,
    IOSK_COUNTER    = 4'h1,
    IOSK_UNIT_AVAIL = 4'h2,
    IOSK_ASM_AVAIL  = 4'h3,
    IOSK_RT_IN      = 4'h4,
    IOSK_RT_OUT     = 4'h5,
    IOSK_PT_STAT    = 4'h6,
    IOSK_ASM_FAULT  = 4'h7,
    IOSK_BUF_FAULT  = 4'h8,
    IOSK_DRUM_FAULT = 4'h9,
    IOSK_PT_FAULT   = 4'ha
  } iosk_kind_t;

endpackage

// ---- rtl/iosk_cmp_if.sv ----
// Operand carrier between the decoder and the magnitude comparator.
// Assumes both ends sit in the same clock domain; the path is combinational.
`timescale 1ns/1ps
interface iosk_cmp_if;
  import iosk_pkg::*;
  logic [0:CQ_W-1] reg_word;  // Addressed register, aligned to the CQ field
  logic [0:CQ_W-1] cq;        // Comparison quantity
  logic            skip;      // High when the register does not exceed CQ

  // Decoder end
  modport dec (output reg_word, output cq, input skip);
  // Comparator end
  modport cmp (input reg_word, input cq, output skip);
endinterface

// ---- rtl/iosk_cmp.sv ----
// Unsigned magnitude compare of register word against comparison quantity.
// Assumes both operands are aligned with position CQ_HI as the top bit.
`timescale 1ns/1ps
module iosk_cmp
  import iosk_pkg::*;
(
  // Operands and verdict
  iosk_cmp_if.cmp cmp_io
);

  // Skip when the register magnitude is less than or equal to CQ
  always_comb begin
    cmp_io.skip = (cmp_io.reg_word <= cmp_io.cq);
  end

endmodule

// ---- testbench/iosk_regs_model.sv ----
// Behavioural information registers standing behind the skip decoder.
// Assumes the bench gives one condition pattern; the unit comes from the word.
`timescale 1ns/1ps
module iosk_regs_model
  import iosk_pkg::*;
(
  // Condition pattern and addressed unit
  input  wire logic [5:15]                      i_cond,
  input  wire logic [1:4]                       i_unit,
  // Register images
  output logic [CNT_HI:CNT_LO]                  o_asm_counter,
  output logic [0:UNITS-1][UAV_HI:UAV_LO]       o_unit_avail,
  output logic [AAV_HI:AAV_LO]                  o_asm_avail,
  output logic [AFL_HI:AFL_LO]                  o_asm_fault,
  output logic [BFL_HI:BFL_LO]                  o_buf_fault,
  output logic [DFL_HI:DFL_LO]                  o_drum_fault,
  output logic [PTS_HI:PTS_LO]                  o_pt_status,
  output logic                                  o_pt_fault,
  output logic [RT_HI:RT_LO]                    o_rt_in_status,
  output logic [RT_HI:RT_LO]                    o_rt_out_status
);
  // ones mark present conditions, four tape registers
  always_comb begin
    for (int u = 0; u < UNITS; u++) begin
      // Units not addressed show the inverse so a wrong pick is seen
      o_unit_avail[u] = (u == int'(i_unit)) ? i_cond[10:13] : ~i_cond[10:13];
    end
  end
  assign o_asm_counter   = i_cond[CNT_HI:CNT_LO];
  assign o_asm_avail     = i_cond[AAV_HI:AAV_LO];
  assign o_asm_fault     = i_cond[AFL_HI:AFL_LO];
  // Mechanical position is driven raw; the decoder must ignore it
  assign o_buf_fault     = i_cond[BFL_HI:BFL_LO];
  assign o_drum_fault    = i_cond[DFL_HI:DFL_LO];
  assign o_pt_status     = i_cond[PTS_HI:PTS_LO];
  assign o_pt_fault      = i_cond[PTF_POS];
  assign o_rt_in_status  = i_cond[RT_HI:RT_LO];
  assign o_rt_out_status = ~i_cond[RT_HI:RT_LO];
endmodule

// ---- testbench/io_status_skip_decoder_tb.sv ----
// Self-checking bench for the skip decoder with its register model.
// Assumes a 250 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
module io_status_skip_decoder_tb;
  import iosk_pkg::*;
  logic clk, rstn, vld;
  logic [0:WORD_W-1] instr;
  logic [5:15] cond;
  logic o_done, o_skip;
  iosk_kind_t o_kind;
  logic [1:4] o_unit;
  logic [CNT_HI:CNT_LO] cnt;
  logic [0:UNITS-1][UAV_HI:UAV_LO] uav;
  logic [AAV_HI:AAV_LO] aav;
  logic [AFL_HI:AFL_LO] afl;
  logic [BFL_HI:BFL_LO] bfl;
  logic [DFL_HI:DFL_LO] dfl;
  logic [PTS_HI:PTS_LO] pts;
  logic ptf;
  logic [RT_HI:RT_LO] rti, rto;
  int n_fail, n_tests, cycles;
  iosk_regs_model i_iosk_regs_model (.i_cond(cond), .i_unit(instr[1:4]),
    .o_asm_counter(cnt), .o_unit_avail(uav), .o_asm_avail(aav), .o_asm_fault(afl),
    .o_buf_fault(bfl), .o_drum_fault(dfl), .o_pt_status(pts), .o_pt_fault(ptf),
    .o_rt_in_status(rti), .o_rt_out_status(rto));
  iosk_decoder i_iosk_decoder (.i_clk(clk), .i_rstn(rstn), .i_instr_valid(vld),
    .i_instr(instr), .i_asm_counter(cnt), .i_unit_avail(uav), .i_asm_avail(aav),
    .i_asm_fault(afl), .i_buf_fault(bfl), .i_drum_fault(dfl), .i_pt_status(pts),
    .i_pt_fault(ptf), .i_rt_in_status(rti), .i_rt_out_status(rto),
    .o_done(o_done), .o_skip(o_skip), .o_kind(o_kind), .o_unit(o_unit));
  // Clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Expected register image, position 5 most significant, unused places zero
  function automatic logic [10:0] img(iosk_kind_t k, logic [10:0] c);
    case (k)
      IOSK_COUNTER:                 return c;
      IOSK_UNIT_AVAIL:              return c & 11'h03c;
      IOSK_ASM_AVAIL:               return c & 11'h0ff;
      IOSK_RT_IN:                   return c & 11'h01c;
      IOSK_RT_OUT:                  return ~c & 11'h01c;
      IOSK_PT_STAT, IOSK_DRUM_FAULT: return c & 11'h003;
      IOSK_ASM_FAULT:               return c & 11'h3ff;
      IOSK_BUF_FAULT:               return c & 11'h00f;
      IOSK_PT_FAULT:                return c & 11'h001;
      default:                      return 11'h000;
    endcase
  endfunction
  function automatic logic [0:WORD_W-1] mk(logic s, logic [3:0] u, logic [10:0] q, logic f);
    logic [0:WORD_W-1] w;
    w = '0;
    w[0] = s;
    w[1:4] = u;
    w[5:15] = q;
    w[16] = f;
    w[21:22] = 2'h3;
    return w;
  endfunction
  // Skip decision: sub-command places count only with the selector set
  function automatic logic exp_skip(logic s, logic [10:0] q, logic [10:0] c, iosk_kind_t k);
    return img(k, c) <= (s ? q : {2'h0, q[8:0]});
  endfunction
  // One skip, issued then judged in the answer cycle
  task automatic run(input logic s, input logic [3:0] u, input logic [10:0] q,
                     input logic f, input logic [10:0] c, input iosk_kind_t k);
    @(negedge clk);
    cond = c;
    instr = mk(s, u, q, f);
    vld = 1'b1;
    @(negedge clk);
    vld = 1'b0;
    chk(o_done, 16'h1);
    chk(o_skip, exp_skip(s, q, c, k));
    chk(o_kind, k);
    chk(o_unit, u);
  endtask
  task automatic t_reset();
    chk(o_done, 16'h0);
    chk(o_skip, 16'h0);
    chk(o_kind, IOSK_NONE);
    chk(o_unit, 16'h0);
    $display("Test reset done");
  endtask
  task automatic t_unit();
    run(1'b0, 4'h5, 11'h004, 1'b0, 11'h004, IOSK_UNIT_AVAIL);
    run(1'b0, 4'h5, 11'h004, 1'b0, 11'h008, IOSK_UNIT_AVAIL);
    $display("Test unit availability done");
  endtask
  task automatic t_counter();
    run(1'b1, 4'h5, 11'h780, 1'b0, 11'h780, IOSK_COUNTER);
    run(1'b1, 4'h5, 11'h780, 1'b0, 11'h781, IOSK_COUNTER);
    $display("Test counter done");
  endtask
  task automatic t_asm_fault();
    run(1'b1, 4'h5, 11'h1ff, 1'b1, 11'h200, IOSK_ASM_FAULT);
    run(1'b1, 4'h5, 11'h1ff, 1'b1, 11'h1ff, IOSK_ASM_FAULT);
    $display("Test assembler fault done");
  endtask
  task automatic t_status_codes();
    iosk_kind_t k[5] = '{IOSK_UNIT_AVAIL, IOSK_ASM_AVAIL, IOSK_RT_IN, IOSK_PT_STAT,
                         IOSK_RT_OUT};
    for (int i = 0; i < 5; i++) begin
      run(1'b0, (i == 2) ? 4'h1 : 4'h0, {(i == 4) ? 2'h2 : 2'(i), 9'h000}, 1'b0,
          11'h604, k[i]);
    end
    $display("Test status codes done");
  endtask
  task automatic t_fault_codes();
    iosk_kind_t k[4] = '{IOSK_BUF_FAULT, IOSK_DRUM_FAULT, IOSK_NONE, IOSK_PT_FAULT};
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 4; i++) begin
        run(1'b0, 4'h3, {2'(i), 9'h000}, 1'b1, j ? 11'h013 : 11'h010, k[i]);
      end
    end
    $display("Test fault codes done");
  endtask
  task automatic t_back2back();
    @(negedge clk);
    cond = 11'h004;
    instr = mk(1'b0, 4'h5, 11'h004, 1'b0);
    vld = 1'b1;
    @(negedge clk);
    instr = mk(1'b1, 4'h2, 11'h000, 1'b0);
    chk(o_skip, 16'h1);
    @(negedge clk);
    vld = 1'b0;
    chk(o_done, 16'h1);
    chk(o_skip, 16'h0);
    chk(o_kind, IOSK_COUNTER);
    chk(o_unit, 4'h2);
    $display("Test back to back done");
  endtask
  // Reset in mid-run clears a held verdict and ignores a request meanwhile
  task automatic t_midreset();
    run(1'b0, 4'h5, 11'h004, 1'b0, 11'h004, IOSK_UNIT_AVAIL);
    @(negedge clk);
    rstn = 1'b0;
    vld = 1'b1;
    @(negedge clk);
    vld = 1'b0;
    chk(o_done, 16'h0);
    chk(o_skip, 16'h0);
    chk(o_kind, IOSK_NONE);
    chk(o_unit, 16'h0);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    run(1'b0, 4'h5, 11'h004, 1'b0, 11'h008, IOSK_UNIT_AVAIL);
    $display("Test mid-run reset done");
  endtask
  initial begin
    rstn = 1'b0;
    vld = 1'b0;
    instr = '0;
    cond = '0;
    n_fail = 0;
    n_tests = 0;
    cycles = 0;
    repeat (10) @(negedge clk);
    t_reset();
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    t_unit();
    t_counter();
    t_asm_fault();
    t_status_codes();
    t_fault_codes();
    t_back2back();
    t_midreset();
    tally_and_finish();
  end
endmodule
